// file: link_regs.svh
// Constants of the isolated fast serial link: frame levels, bit counts,
// host command codes and clock divider settings.
// Assumes inclusion by bare name from the package and both link ends.
`ifndef LINK_REGS_SVH
`define LINK_REGS_SVH

`define LINK_START_LEVEL 1'h0
`define LINK_IDLE_LEVEL 1'h1
`define LINK_SOURCE_BIT 1'h0
`define LINK_DESTINATION_SELECT_BIT_BIT 1'h0
`define LINK_DATA_LAST 3'h7
`define LINK_DESTINATION_SELECT_BIT_IDX 4'h8
`define LINK_CMD_HOLD 8'h10
`define LINK_CMD_RELEASE 8'h00
`define LINK_STRAP_WAIT 2'h3
`define LINK_HALF_LAST 3'h3

`endif

// file: link_pkg.sv
// Types shared by both ends of the isolated fast serial link.
// Assumes link_regs.svh is on the include path.
package link_pkg;
    `include "link_regs.svh"

    // Transmit sequencer, one-hot
    typedef enum logic [2:0] {
        TX_IDLE = 3'h1,
        TX_DATA = 3'h2,
        TX_LAST = 3'h4
    } tx_state_e;

    // Device state on the system clock
    typedef struct packed {
        logic cfgS1;
        logic cfgS2;
        logic [1:0] strapCnt;
        logic fastEn;
        logic hold;
        logic runLvl;
        logic txReq;
        logic [7:0] txData;
        logic txAckS1;
        logic txAckS2;
        logic rxReqS1;
        logic rxReqS2;
        logic rxSeen;
        logic rxAck;
        logic [7:0] rxData;
        logic rxValid;
    } dev_sys_s;

    // Device state on the link clock
    typedef struct packed {
        logic runS1;
        logic runS2;
        logic txReqS1;
        logic txReqS2;
        logic txSeen;
        logic txAck;
        tx_state_e txState;
        logic [2:0] txCnt;
        logic [7:0] txShift;
        logic serialOut;
        logic rxBusy;
        logic [3:0] rxCnt;
        logic [7:0] rxShift;
        logic [7:0] rxHold;
        logic rxReq;
        logic rxAckS1;
        logic rxAckS2;
        logic cts;
    } dev_link_s;

    // External end state, single clock
    typedef struct packed {
        logic linkClk;
        logic [2:0] divCnt;
        logic soS1;
        logic soS2;
        logic ctsS1;
        logic ctsS2;
        logic ctsSeen;
        logic serialIn;
        tx_state_e txState;
        logic [2:0] txCnt;
        logic [7:0] txShift;
        logic rxBusy;
        logic [3:0] rxCnt;
        logic [7:0] rxShift;
        logic [7:0] recvData;
        logic recvValid;
    } ext_s;
endpackage

// file: link_if.sv
// Four wires of the isolated fast serial link.
// Assumes the external end drives the clock and the bench joins both ends.
`timescale 1ns/1ps
interface link_if;
    logic isolatedLinkClock;
    logic linkSerialOut;
    logic linkSerialIn;
    logic linkClearToSend;

    // Documented device end
    modport device (
        input isolatedLinkClock,
        input linkSerialIn,
        output linkSerialOut,
        output linkClearToSend
    );

    // External party end, source of the clock
    modport ext (
        output isolatedLinkClock,
        output linkSerialIn,
        input linkSerialOut,
        input linkClearToSend
    );
endinterface

// file: fast_serial_device.sv
// Device end of the isolated fast serial link: one-byte send holding
// register, one-byte receive register, hold-in-reset command handling.
// Assumes the far end supplies the link clock and keeps its own rules.
`timescale 1ns/1ps
module fast_serial_device
    import link_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic cfgFastSerial,
    input wire logic [7:0] hostData,
    input wire logic hostValid,
    output logic hostReady,
    input wire logic cmdValid,
    input wire logic [7:0] cmdCode,
    output logic [7:0] rxData,
    output logic rxValid,
    input wire logic rxReady,
    output logic linkHeld,
    link_if.device link
);
    `include "link_regs.svh"

    localparam dev_sys_s SYS_RST = '{default: '0};
    localparam dev_link_s LINK_RST = '{
        txState: TX_IDLE,
        serialOut: `LINK_IDLE_LEVEL,
        default: '0
    };

    dev_sys_s sq;
    dev_sys_s sn;
    dev_link_s lq;
    dev_link_s ln;
    logic inSample;
    logic rxStart;
    logic txAvail;

    // System side: strap capture, command decode, send and receive handshakes
    always_comb begin
        sn = sq;
        // Strap is a pin, so it is synchronised before it is caught
        sn.cfgS1 = cfgFastSerial;
        sn.cfgS2 = sq.cfgS1;
        if (sq.strapCnt != `LINK_STRAP_WAIT) begin
            sn.strapCnt = sq.strapCnt + 2'h1;
        end
        if (sq.strapCnt == (`LINK_STRAP_WAIT - 2'h1)) begin
            sn.fastEn = sq.cfgS2;
        end
        if (cmdValid) begin
            if (cmdCode == `LINK_CMD_HOLD) begin
                sn.hold = 1'b1;
            end else if (cmdCode == `LINK_CMD_RELEASE) begin
                sn.hold = 1'b0;
            end
        end
        // Registered so the link side sees one clean level
        sn.runLvl = sq.fastEn & ~sq.hold;
        // Send holding register: toggle request, wait for matching ack
        sn.txAckS1 = lq.txAck;
        sn.txAckS2 = sq.txAckS1;
        if (hostValid && hostReady) begin
            sn.txData = hostData;
            sn.txReq = ~sq.txReq;
        end
        // Receive: new byte only copied once the previous one was taken
        sn.rxReqS1 = lq.rxReq;
        sn.rxReqS2 = sq.rxReqS1;
        if (sq.rxValid && rxReady) begin
            sn.rxValid = 1'b0;
            sn.rxAck = sq.rxSeen;
        end else if (!sq.rxValid && (sq.rxReqS2 != sq.rxSeen)) begin
            sn.rxData = lq.rxHold;
            sn.rxValid = 1'b1;
            sn.rxSeen = sq.rxReqS2;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sq <= SYS_RST;
        end else begin
            sq <= sn;
        end
    end

    // Host data is still taken while held; it just waits in the register
    assign hostReady = sq.fastEn & (sq.txAckS2 == sq.txReq);
    assign rxData = sq.rxData;
    assign rxValid = sq.rxValid;
    assign linkHeld = sq.hold;

    // Incoming line is sampled on the falling edge, half a period after the
    // far end changes it on the rising edge
    always_ff @(negedge link.isolatedLinkClock or negedge arst_n) begin
        if (!arst_n) begin
            inSample <= `LINK_IDLE_LEVEL;
        end else begin
            inSample <= link.linkSerialIn;
        end
    end

    // Start bit seen while the device was offering to receive
    assign rxStart = !lq.rxBusy && lq.cts && (inSample == `LINK_START_LEVEL);
    assign txAvail = lq.runS2 && (lq.txReqS2 != lq.txSeen);

    // Link side, all outputs change on the rising edge of the far-end clock
    always_comb begin
        ln = lq;
        ln.runS1 = sq.runLvl;
        ln.runS2 = lq.runS1;
        ln.txReqS1 = sq.txReq;
        ln.txReqS2 = lq.txReqS1;
        ln.rxAckS1 = sq.rxAck;
        ln.rxAckS2 = lq.rxAckS1;
        // Receiver
        if (!lq.rxBusy) begin
            if (rxStart) begin
                ln.rxBusy = 1'b1;
                ln.rxCnt = 4'h0;
                ln.cts = 1'b0;
            end else begin
                ln.cts = lq.runS2 && (lq.rxReq == lq.rxAckS2);
            end
        end else if (lq.rxCnt == `LINK_DESTINATION_SELECT_BIT_IDX) begin
            ln.rxBusy = 1'b0;
            // Any other destination has no store here, so the byte is dropped
            if (inSample == `LINK_DESTINATION_SELECT_BIT_BIT) begin
                ln.rxHold = lq.rxShift;
                ln.rxReq = ~lq.rxReq;
            end
        end else begin
            ln.rxShift = {inSample, lq.rxShift[7:1]};
            ln.rxCnt = lq.rxCnt + 4'h1;
        end
        // Transmitter; a stopped clock simply freezes it mid-frame
        case (lq.txState)
            TX_IDLE: begin
                if (txAvail && !lq.rxBusy && !rxStart) begin
                    ln.serialOut = `LINK_START_LEVEL;
                    ln.txShift = sq.txData;
                    ln.txCnt = 3'h0;
                    ln.txSeen = lq.txReqS2;
                    ln.txState = TX_DATA;
                end else begin
                    ln.serialOut = `LINK_IDLE_LEVEL;
                end
            end
            TX_DATA: begin
                ln.serialOut = lq.txShift[0];
                ln.txShift = {1'b0, lq.txShift[7:1]};
                ln.txCnt = lq.txCnt + 3'h1;
                if (lq.txCnt == `LINK_DATA_LAST) begin
                    ln.txState = TX_LAST;
                end
            end
            TX_LAST: begin
                ln.serialOut = `LINK_SOURCE_BIT;
                ln.txAck = lq.txSeen;
                ln.txState = TX_IDLE;
            end
            default: begin
                ln.serialOut = `LINK_IDLE_LEVEL;
                ln.txState = TX_IDLE;
            end
        endcase
    end

    always_ff @(posedge link.isolatedLinkClock or negedge arst_n) begin
        if (!arst_n) begin
            lq <= LINK_RST;
        end else begin
            lq <= ln;
        end
    end

    assign link.linkSerialOut = lq.serialOut;
    assign link.linkClearToSend = lq.cts;
endmodule

// file: fast_serial_ext.sv
// External party end of the isolated fast serial link: makes the link
// clock by dividing its own clock, sends and receives one byte at a time.
// Assumes the device end is joined through link_if.
`timescale 1ns/1ps
module fast_serial_ext
    import link_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [7:0] sendData,
    input wire logic sendValid,
    output logic sendReady,
    input wire logic recvStall,
    output logic [7:0] recvData,
    output logic recvValid,
    link_if.ext link
);
    `include "link_regs.svh"

    localparam ext_s EXT_RST = '{
        txState: TX_IDLE,
        serialIn: `LINK_IDLE_LEVEL,
        soS1: `LINK_IDLE_LEVEL,
        soS2: `LINK_IDLE_LEVEL,
        default: '0
    };

    ext_s q;
    ext_s n;
    logic tick;
    logic rise;
    logic fall;
    logic stall;
    logic sampleEv;

    // Clock phase events; sampling happens just before the clock falls
    assign tick = (q.divCnt == `LINK_HALF_LAST);
    assign rise = tick && !q.linkClk;
    assign fall = tick && q.linkClk;
    // Start bit seen while unable to take a byte: clock held high
    assign stall = fall && !q.rxBusy && (q.soS2 == `LINK_START_LEVEL) && recvStall;
    assign sampleEv = fall && !stall;
    assign sendReady = rise && (q.txState == TX_IDLE) && q.ctsSeen;

    always_comb begin
        n = q;
        n.recvValid = 1'b0;
        // Device outputs belong to its clock, so they pass two flops
        n.soS1 = link.linkSerialOut;
        n.soS2 = q.soS1;
        n.ctsS1 = link.linkClearToSend;
        n.ctsS2 = q.ctsS1;
        n.divCnt = tick ? 3'h0 : (q.divCnt + 3'h1);
        if (tick && !stall) begin
            n.linkClk = ~q.linkClk;
        end
        // Receive and flow-control sampling on the falling edge
        if (sampleEv) begin
            n.ctsSeen = q.ctsS2;
            if (!q.rxBusy) begin
                if (q.soS2 == `LINK_START_LEVEL) begin
                    n.rxBusy = 1'b1;
                    n.rxCnt = 4'h0;
                end
            end else if (q.rxCnt == `LINK_DESTINATION_SELECT_BIT_IDX) begin
                // Source bit closes the frame
                n.rxBusy = 1'b0;
                n.recvData = q.rxShift;
                n.recvValid = 1'b1;
            end else begin
                n.rxShift = {q.soS2, q.rxShift[7:1]};
                n.rxCnt = q.rxCnt + 4'h1;
            end
        end
        // Send on the rising edge, so the device samples mid-bit
        if (rise) begin
            case (q.txState)
                TX_IDLE: begin
                    if (sendValid && sendReady) begin
                        n.serialIn = `LINK_START_LEVEL;
                        n.txShift = sendData;
                        n.txCnt = 3'h0;
                        n.txState = TX_DATA;
                    end else begin
                        n.serialIn = `LINK_IDLE_LEVEL;
                    end
                end
                TX_DATA: begin
                    n.serialIn = q.txShift[0];
                    n.txShift = {1'b0, q.txShift[7:1]};
                    n.txCnt = q.txCnt + 3'h1;
                    if (q.txCnt == `LINK_DATA_LAST) begin
                        n.txState = TX_LAST;
                    end
                end
                TX_LAST: begin
                    n.serialIn = `LINK_DESTINATION_SELECT_BIT_BIT;
                    n.txState = TX_IDLE;
                end
                default: begin
                    n.serialIn = `LINK_IDLE_LEVEL;
                    n.txState = TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= EXT_RST;
        end else begin
            q <= n;
        end
    end

    assign link.isolatedLinkClock = q.linkClk;
    assign link.linkSerialIn = q.serialIn;
    assign recvData = q.recvData;
    assign recvValid = q.recvValid;
endmodule

// file: link_properties.sv
// Concurrent checks on the four wires between the two link ends.
// Assumes the bench instantiates it beside the joining interface.
`timescale 1ns/1ps
module link_properties (
    input wire logic arst_n,
    input wire logic isolatedLinkClock,
    input wire logic linkSerialOut,
    input wire logic linkSerialIn,
    input wire logic linkClearToSend
);
    logic [3:0] txCnt;
    logic [3:0] rxCnt;
    logic outAtFall;
    logic ctsAtFall;
    logic txStart;
    logic rxStart;
    assign txStart = (txCnt == 4'h0) && !linkSerialOut;
    assign rxStart = (rxCnt == 4'h0) && !linkSerialIn;
    // Bit counters per direction; falling edge is mid-bit, so no race
    always_ff @(negedge isolatedLinkClock or negedge arst_n) begin
        if (!arst_n) begin
            txCnt <= 4'h0;
            rxCnt <= 4'h0;
            outAtFall <= 1'h1;
            ctsAtFall <= 1'h0;
        end else begin
            txCnt <= (txCnt == 4'h0) ? {3'h0, txStart} : ((txCnt == 4'h9) ? 4'h0 : txCnt + 4'h1);
            rxCnt <= (rxCnt == 4'h0) ? {3'h0, rxStart} : ((rxCnt == 4'h9) ? 4'h0 : rxCnt + 4'h1);
            outAtFall <= linkSerialOut;
            ctsAtFall <= linkClearToSend;
        end
    end
    default clocking @(negedge isolatedLinkClock); endclocking
    default disable iff (!arst_n);
    property p_ctsDrop;
        rxStart |=> !linkClearToSend;
    endproperty
    a_ctsDrop: assert property (p_ctsDrop) else $error("clear-to-send kept high after start");
    property p_startNeedsCts;
        rxStart |-> linkClearToSend;
    endproperty
    a_startNeedsCts: assert property (p_startNeedsCts) else $error("frame begun without clear-to-send");
    property p_ctsLowInFrame;
        rxCnt != 4'h0 |-> !linkClearToSend;
    endproperty
    a_ctsLowInFrame: assert property (p_ctsLowInFrame) else $error("clear-to-send high in a frame");
    property p_ctsStaysLow;
        rxCnt == 4'h9 |=> !linkClearToSend [*2];
    endproperty
    a_ctsStaysLow: assert property (p_ctsStaysLow) else $error("clear-to-send back before byte taken");
    property p_noTxInRx;
        txStart |-> rxCnt == 4'h0;
    endproperty
    a_noTxInRx: assert property (p_noTxInRx) else $error("send started while receiving");
    property p_sourceZero;
        txCnt == 4'h9 |-> !linkSerialOut ##1 linkSerialOut;
    endproperty
    a_sourceZero: assert property (p_sourceZero) else $error("source bit or idle level wrong");
    property p_outOnRise;
        @(posedge isolatedLinkClock) disable iff (!arst_n) linkSerialOut == outAtFall;
    endproperty
    a_outOnRise: assert property (p_outOnRise) else $error("serial out moved on falling edge");
    property p_ctsOnRise;
        @(posedge isolatedLinkClock) disable iff (!arst_n) linkClearToSend == ctsAtFall;
    endproperty
    a_ctsOnRise: assert property (p_ctsOnRise) else $error("clear-to-send moved on falling edge");
    c_txFrame: cover property (txCnt == 4'h9);
    c_rxFrame: cover property (rxCnt == 4'h9);
    c_overlap: cover property (txCnt != 4'h0 && rxCnt != 4'h0);
endmodule

// file: isolated_fast_serial_link_tb.sv
// Bench joining both link ends, plus a second device fed faulty frames.
// Assumes the design files and link_regs.svh are compiled alongside.
`timescale 1ns/1ps
`include "link_regs.svh"
module isolated_fast_serial_link_tb import link_pkg::*; ;
    logic clk = 1'h0;
    // Left unknown at time zero so the first assertion is a real falling edge
    // and the link-clock flops, whose clock is still, reset as well
    logic arst_n;
    logic cfgFastSerial = 1'h0;
    logic hostValid = 1'h0, cmdValid = 1'h0, rxReady = 1'h0, sendValid = 1'h0, recvStall = 1'h0;
    logic [7:0] hostData = 8'h00, cmdCode = 8'h00, sendData = 8'h00;
    logic hostReady, rxValid, linkHeld, sendReady, recvValid, rx2Valid;
    logic [7:0] rxData, recvData, rx2Data, osh, ish;
    logic [7:0] txQ[$], rxQ[$], txW[$], rxW[$], faultQ[$];
    int error_cnt = 0, comparisons = 0, seed = 79, recvCnt = 0, oc = 0, ic = 0, n;
    link_if lk();
    link_if lk2();
    fast_serial_device fast_serial_device_inst (.clk, .arst_n, .cfgFastSerial, .hostData,
        .hostValid, .hostReady, .cmdValid, .cmdCode, .rxData, .rxValid, .rxReady, .linkHeld,
        .link(lk.device));
    fast_serial_ext fast_serial_ext_inst (.clk, .arst_n, .sendData, .sendValid, .sendReady,
        .recvStall, .recvData, .recvValid, .link(lk.ext));
    // Fault target: its far end is the bench, so its reader input stays low
    fast_serial_device fast_serial_device_inst2 (.clk, .arst_n, .cfgFastSerial, .hostData,
        .hostValid, .hostReady(), .cmdValid, .cmdCode, .rxData(rx2Data), .rxValid(rx2Valid),
        .rxReady(1'h0), .linkHeld(), .link(lk2.device));
    link_properties link_properties_inst (.arst_n, .isolatedLinkClock(lk.isolatedLinkClock),
        .linkSerialOut(lk.linkSerialOut), .linkSerialIn(lk.linkSerialIn),
        .linkClearToSend(lk.linkClearToSend));

    initial begin
        forever #50 clk = ~clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("Counts: %0d comparisons, %0d errors", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic doReset(input logic cfg);
        @(posedge clk);
        arst_n <= 1'h0;
        cfgFastSerial <= cfg;
        repeat (3) @(posedge clk);
        arst_n <= 1'h1;
    endtask

    // Offers one byte at either end and holds it until taken
    task automatic xfer(input logic toDev, input logic [7:0] d);
        int k;
        @(posedge clk);
        if (toDev) begin
            sendData <= d;
            sendValid <= 1'h1;
            rxQ.push_back(d);
            rxW.push_back(d);
        end else begin
            hostData <= d;
            hostValid <= 1'h1;
            txQ.push_back(d);
            txW.push_back(d);
        end
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while ((toDev ? sendReady : hostReady) !== 1'h1 && k < 4000);
        if (toDev)
            sendValid <= 1'h0;
        else
            hostValid <= 1'h0;
    endtask

    task automatic cmd(input logic [7:0] c, input logic held);
        @(posedge clk);
        cmdCode <= c;
        cmdValid <= 1'h1;
        @(posedge clk);
        cmdValid <= 1'h0;
        @(negedge clk);
        chk({7'h0, linkHeld}, {7'h0, held});
    endtask

    task automatic waitDone();
        for (int k = 0; k < 20000 && (txQ.size() + rxQ.size()) != 0; k++)
            @(posedge clk);
    endtask

    // Bench-made clock for the fault link: runs only in sendRaw, idle ticks until clear-to-send, then the frame
    task automatic tick(input logic b);
        lk2.isolatedLinkClock = 1'h1;
        lk2.linkSerialIn = b;
        #6;
        lk2.isolatedLinkClock = 1'h0;
        #6;
    endtask

    task automatic sendRaw(input logic [9:0] f);
        #3;
        for (int k = 0; k < 60 && lk2.linkClearToSend !== 1'h1; k++)
            tick(1'h1);
        for (int k = 0; k < 12; k++)
            tick(k < 10 ? f[k] : 1'h1);
    endtask

    // Wire decoder: start, eight bits, then the zero routing bit
    task automatic mon(input logic b, inout int c, inout logic [7:0] s, ref logic [7:0] q[$]);
        if (c == 0)
            c = (b === 1'h0) ? 1 : 0;
        else if (c < 9) begin
            s = {b, s[7:1]};
            c++;
        end else begin
            chk(s, q.pop_front());
            chk({7'h0, b}, 8'h00);
            c = 0;
        end
    endtask

    always @(negedge lk.isolatedLinkClock) begin
        mon(lk.linkSerialOut, oc, osh, txW);
        mon(lk.linkSerialIn, ic, ish, rxW);
    end

    // Random reader and stall pressure; stalls stop the link clock
    always @(posedge clk) begin
        rxReady <= 1'($random(seed));
        recvStall <= (($random(seed) & 3) == 0);
    end

    // Delivered bytes against the oldest note of each direction
    always @(posedge clk) begin
        if (recvValid === 1'h1) begin
            chk(recvData, txQ.pop_front());
            recvCnt++;
        end
        if (rxValid === 1'h1 && rxReady === 1'h1)
            chk(rxData, rxQ.pop_front());
    end

    always @(posedge rx2Valid) begin
        #1 chk(rx2Data, faultQ.pop_front());
    end

    initial begin
        lk2.isolatedLinkClock = 1'h0;
        lk2.linkSerialIn = 1'h1;
        doReset(1'h0);
        repeat (40) @(posedge clk);
        chk({7'h0, hostReady}, 8'h00);
        doReset(1'h1);
        fork
            for (int i = 0; i < 12; i++) xfer(1'h0, (i < 2) ? {8{i[0]}} : 8'($random(seed)));
            for (int i = 0; i < 12; i++) xfer(1'h1, (i < 2) ? {8{i[0]}} : 8'($random(seed)));
        join
        waitDone();
        cmd(`LINK_CMD_HOLD, 1'h1);
        cmd(8'h02, 1'h1);
        n = recvCnt;
        xfer(1'h0, 8'hA5);
        repeat (400) @(posedge clk);
        chk(8'(recvCnt), 8'(n));
        cmd(`LINK_CMD_RELEASE, 1'h0);
        waitDone();
        chk(8'(txQ.size() + rxQ.size()), 8'h00);
        sendRaw({1'h1, 8'h3C, 1'h0});
        repeat (20) @(posedge clk);
        chk({7'h0, rx2Valid}, 8'h00);
        faultQ.push_back(8'hC3);
        sendRaw({1'h0, 8'hC3, 1'h0});
        repeat (20) @(posedge clk);
        chk(8'(faultQ.size()), 8'h00);
        conclude();
    end

    // Whole run needs well under 15000 cycles
    initial begin
        #3000000;
        error_cnt++;
        conclude();
    end
endmodule
